// ===== dpc_pkg.sv
/*
  Package for the drive profile control and status register bank.
  Assumes one device clock; object access comes through a plain object port.
*/
`default_nettype none
package dpc_pkg;
  // ==========================================================
  // Object indexes
  localparam logic [15:0] IDX_ERROR  = 16'h603f;
  localparam logic [15:0] IDX_CTRL   = 16'h6040;
  localparam logic [15:0] IDX_STATUS = 16'h6041;
  localparam logic [15:0] IDX_QSOPT  = 16'h605a;
  // ==========================================================
  // Reset values and fields
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] QSOPT_RST  = 16'h0002;
  localparam logic [7:0]  ERR_HIGH   = 8'hff;
  localparam logic [15:0] ERR_NONE   = 16'h0000;
  localparam int          CW_FAULT_RST = 7;
  localparam int          CW_HALT      = 8;
  localparam int          SW_WARN      = 7;
  localparam int          SW_REMOTE    = 9;
  localparam int          SW_ILIMIT    = 11;
  // ==========================================================
  // Drive states
  typedef enum logic [2:0] {
    DPC_NOT_READY,
    DPC_SW_DISABLED,
    DPC_READY,
    DPC_SWITCHED_ON,
    DPC_OP_ENABLED,
    DPC_QS_ACTIVE,
    DPC_FAULT_REACT,
    DPC_FAULT
  } dpc_state_t;
endpackage
`default_nettype wire

// ===== dpc_obj_if.sv
/*
  Interface carrying the drive state between the bank and the state machine.
  Assumes both ends share sys_clk.
*/
`default_nettype none
interface dpc_obj_if;
  logic [15:0]         ctrl;
  logic                alarm;
  logic                init_done;
  logic                motor_stopped;
  logic [15:0]         qs_opt;
  dpc_pkg::dpc_state_t state;
  logic                cur_off;
  modport bank (output ctrl, alarm, init_done, motor_stopped, qs_opt, input state, cur_off);
  modport fsm  (input ctrl, alarm, init_done, motor_stopped, qs_opt, output state, cur_off);
endinterface
`default_nettype wire

// ===== dpc_state_fsm.sv
/*
  Drive state machine stepped by control word bits 0 to 3.
  Assumes inputs are synchronous to sys_clk.
*/
`default_nettype none
module dpc_state_fsm (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Object link
  dpc_obj_if.fsm    obj
);
  dpc_pkg::dpc_state_t state_ff;
  dpc_pkg::dpc_state_t nxt_state;
  logic so, ev, qs, eo;

  // ==========================================================
  // Command decode
  always_comb
  begin
    so = obj.ctrl[0];
    ev = obj.ctrl[1];
    qs = obj.ctrl[2];
    eo = obj.ctrl[3];
    nxt_state = state_ff;
    unique case (state_ff)
      dpc_pkg::DPC_NOT_READY:
        if (obj.init_done)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
      dpc_pkg::DPC_SW_DISABLED:
        if (ev && qs && !so)
          nxt_state = dpc_pkg::DPC_READY;
      dpc_pkg::DPC_READY:
        if (!ev || !qs)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
        else if (so)
          nxt_state = dpc_pkg::DPC_SWITCHED_ON;
      dpc_pkg::DPC_SWITCHED_ON:
        if (!ev || !qs)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
        else if (!so)
          nxt_state = dpc_pkg::DPC_READY;
        else if (eo)
          nxt_state = dpc_pkg::DPC_OP_ENABLED;
      dpc_pkg::DPC_OP_ENABLED:
        if (!ev)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
        else if (!qs)
          nxt_state = dpc_pkg::DPC_QS_ACTIVE;
        else if (!so)
          nxt_state = dpc_pkg::DPC_READY;
        else if (!eo)
          nxt_state = dpc_pkg::DPC_SWITCHED_ON;
      dpc_pkg::DPC_QS_ACTIVE:
        if (!ev)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
        else if (obj.motor_stopped && obj.qs_opt[2:0] <= 3'h3)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
      dpc_pkg::DPC_FAULT_REACT:
        if (obj.motor_stopped)
          nxt_state = dpc_pkg::DPC_FAULT;
      dpc_pkg::DPC_FAULT:
        if (!obj.alarm)
          nxt_state = dpc_pkg::DPC_SW_DISABLED;
    endcase
    if (obj.alarm && state_ff != dpc_pkg::DPC_FAULT && state_ff != dpc_pkg::DPC_FAULT_REACT)
      nxt_state = dpc_pkg::DPC_FAULT_REACT;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= dpc_pkg::DPC_NOT_READY;
    else
      state_ff <= nxt_state;
  end

  assign obj.state   = state_ff;
  assign obj.cur_off = (state_ff == dpc_pkg::DPC_QS_ACTIVE) && (obj.qs_opt[2:0] == 3'h0);

  fault_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (obj.alarm && state_ff != dpc_pkg::DPC_FAULT && state_ff != dpc_pkg::DPC_FAULT_REACT)
     |=> state_ff == dpc_pkg::DPC_FAULT_REACT)
    else $error("alarm did not enter fault reaction");
  qs_exit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == dpc_pkg::DPC_QS_ACTIVE && obj.motor_stopped && obj.ctrl[1] && !obj.alarm
     && obj.qs_opt[2:0] >= 3'h5) |=> state_ff == dpc_pkg::DPC_QS_ACTIVE)
    else $error("quick stop left for options 5 to 7");
endmodule
`default_nettype wire

// ===== dpc_bank.sv
/*
  Drive profile control and status object bank.
  Assumes the object port is synchronous to sys_clk; alarm, information and
  limit inputs come from pins and are filtered here; init_done and motor_stopped pass unfiltered.
*/
`default_nettype none
module dpc_bank (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Object access
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [15:0] obj_wdata,
  output logic      [15:0] obj_rdata,
  // Drive conditions from pins
  input  wire logic        alarm_raise,
  input  wire logic [7:0]  alarm_code,
  input  wire logic        info_cond,
  input  wire logic        limit_cond,
  input  wire logic        init_done,
  input  wire logic        motor_stopped,
  // Drive commands
  output logic      [2:0]  mode_bits,
  output logic             halt_req,
  output logic      [2:0]  stop_mode,
  output logic             current_off
);
  dpc_obj_if obj ();

  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [15:0] qsopt_ff, nxt_qsopt;
  logic [15:0] qspend_ff, nxt_qspend;
  logic        pend_ff, nxt_pend;
  logic        alarm_ff, nxt_alarm;
  logic [7:0]  code_ff, nxt_code;
  logic        fr_prev_ff;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] err_word, status_word;
  logic [2:0]  s1_ff, s2_ff, s3_ff, cond_ff, nxt_cond;
  logic [7:0]  cs1_ff, cs2_ff, cs3_ff, code_sync_ff, nxt_code_sync;
  logic        qs_running;

  function automatic logic legal_qs(input logic [15:0] v);
    legal_qs = (v <= 16'h0007) && (v != 16'h0004);
  endfunction

  // ==========================================================
  // Pin filtering: a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      s3_ff <= 3'h0;
      cond_ff <= 3'h0;
      cs1_ff <= 8'h00;
      cs2_ff <= 8'h00;
      cs3_ff <= 8'h00;
      code_sync_ff <= 8'h00;
    end
    else
    begin
      s1_ff <= {alarm_raise, info_cond, limit_cond};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      cond_ff <= nxt_cond;
      cs1_ff <= alarm_code;
      cs2_ff <= cs1_ff;
      cs3_ff <= cs2_ff;
      code_sync_ff <= nxt_code_sync;
    end
  end

  always_comb
  begin
    // Whole code word taken only when both stages agree
    nxt_code_sync = (cs2_ff == cs3_ff) ? cs3_ff : code_sync_ff;
    for (int i = 0; i < 3; i++)
      nxt_cond[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : cond_ff[i];
  end

  // ==========================================================
  // Object registers
  assign qs_running = (obj.state == dpc_pkg::DPC_QS_ACTIVE) && !motor_stopped;

  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_qsopt  = qsopt_ff;
    nxt_qspend = qspend_ff;
    nxt_pend   = pend_ff;
    nxt_alarm  = alarm_ff;
    nxt_code   = code_ff;
    if (obj_wr && obj_index == dpc_pkg::IDX_CTRL)
      nxt_ctrl = obj_wdata;
    if (obj_wr && obj_index == dpc_pkg::IDX_QSOPT && legal_qs(obj_wdata))
    begin
      if (qs_running)
      begin
        nxt_qspend = obj_wdata;
        nxt_pend   = 1'b1;
      end
      else
      begin
        nxt_qsopt = obj_wdata;
        nxt_pend  = 1'b0;
      end
    end
    else if (pend_ff && !qs_running)
    begin
      nxt_qsopt = qspend_ff;
      nxt_pend  = 1'b0;
    end
    if (ctrl_ff[dpc_pkg::CW_FAULT_RST] && !fr_prev_ff)
      nxt_alarm = 1'b0;
    // New alarm wins over the clear
    if (cond_ff[2] && !alarm_ff)
    begin
      nxt_alarm = 1'b1;
      nxt_code  = code_sync_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_ff    <= dpc_pkg::CTRL_RST;
      qsopt_ff   <= dpc_pkg::QSOPT_RST;
      qspend_ff  <= dpc_pkg::QSOPT_RST;
      pend_ff    <= 1'b0;
      alarm_ff   <= 1'b0;
      code_ff    <= 8'h00;
      fr_prev_ff <= 1'b0;
      rdata_ff   <= 16'h0000;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      qsopt_ff   <= nxt_qsopt;
      qspend_ff  <= nxt_qspend;
      pend_ff    <= nxt_pend;
      alarm_ff   <= nxt_alarm;
      code_ff    <= nxt_code;
      fr_prev_ff <= ctrl_ff[dpc_pkg::CW_FAULT_RST];
      rdata_ff   <= nxt_rdata;
    end
  end

  // ==========================================================
  // Read words
  always_comb
  begin
    // alarm code with FF high byte
    err_word = alarm_ff ? {dpc_pkg::ERR_HIGH, code_ff} : dpc_pkg::ERR_NONE;
    status_word = 16'h0000;
    unique case (obj.state)
      dpc_pkg::DPC_NOT_READY:   status_word[6:0] = 7'h00;
      dpc_pkg::DPC_SW_DISABLED: status_word[6:0] = 7'h40;
      dpc_pkg::DPC_READY:       status_word[6:0] = 7'h21;
      dpc_pkg::DPC_SWITCHED_ON: status_word[6:0] = 7'h33;
      dpc_pkg::DPC_OP_ENABLED:  status_word[6:0] = 7'h37;
      dpc_pkg::DPC_QS_ACTIVE:   status_word[6:0] = 7'h17;
      dpc_pkg::DPC_FAULT_REACT: status_word[6:0] = 7'h1f;
      dpc_pkg::DPC_FAULT:       status_word[6:0] = 7'h08;
    endcase
    status_word[dpc_pkg::SW_WARN]   = cond_ff[1];
    status_word[dpc_pkg::SW_REMOTE] = init_done;
    status_word[dpc_pkg::SW_ILIMIT] = cond_ff[0];
    unique case (obj_index)
      dpc_pkg::IDX_ERROR:  nxt_rdata = err_word;
      dpc_pkg::IDX_CTRL:   nxt_rdata = ctrl_ff;
      dpc_pkg::IDX_STATUS: nxt_rdata = status_word;
      dpc_pkg::IDX_QSOPT:  nxt_rdata = qsopt_ff;
      default:             nxt_rdata = 16'h0000;
    endcase
  end

  assign obj_rdata = rdata_ff;

  // ==========================================================
  // State machine link
  assign obj.ctrl          = ctrl_ff;
  assign obj.alarm         = alarm_ff;
  assign obj.init_done     = init_done;
  assign obj.motor_stopped = motor_stopped;
  assign obj.qs_opt        = qsopt_ff;

  dpc_state_fsm u_fsm (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .obj     (obj)
  );

  // mode bits passed to active mode
  assign mode_bits   = ctrl_ff[6:4];
  assign halt_req    = ctrl_ff[dpc_pkg::CW_HALT] && (obj.state == dpc_pkg::DPC_OP_ENABLED);
  assign stop_mode   = (obj.state == dpc_pkg::DPC_QS_ACTIVE) ? qsopt_ff[2:0] : 3'h0;
  assign current_off = obj.cur_off;

  // ==========================================================
  // Checks
  sequence fr_rise_s;
    (alarm_ff && !ctrl_ff[dpc_pkg::CW_FAULT_RST]) ##1 ctrl_ff[dpc_pkg::CW_FAULT_RST];
  endsequence
  alarm_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fr_rise_s |=> !alarm_ff)
    else $error("fault reset edge did not clear alarm");
  alarm_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (alarm_ff && !(ctrl_ff[7] && !fr_prev_ff)) |=> alarm_ff)
    else $error("alarm cleared without edge");
  err_word_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    alarm_ff |-> err_word[15:8] == 8'hff && err_word[7:0] == code_ff)
    else $error("error code high byte wrong");
  err_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !alarm_ff |-> err_word == 16'h0000)
    else $error("error code not zero");
  qs_legal_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    legal_qs(qsopt_ff))
    else $error("illegal quick stop option held");
  qs_defer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    qs_running |=> qsopt_ff == $past(qsopt_ff))
    else $error("option changed during quick stop");
  ro_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (obj_wr && obj_index == 16'h603f) |=> ctrl_ff == $past(ctrl_ff))
    else $error("read-only write changed control");
  warn_track_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    status_word[7] == cond_ff[1])
    else $error("warning bit does not track condition");
  remote_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !init_done |-> !status_word[9])
    else $error("remote set before init");
  halt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halt_req |-> obj.state == dpc_pkg::DPC_OP_ENABLED)
    else $error("halt outside operation enabled");
endmodule
`default_nettype wire

// ===== dpc_master_model.sv
/*
  Fieldbus master model: writes and reads drive profile objects.
  Assumes the bank takes a write on the rising edge with obj_wr high.
*/
`default_nettype none
module dpc_master_model (
  // Clock
  input  wire logic        sys_clk,
  // Object access
  output logic             obj_wr,
  output logic      [15:0] obj_index,
  output logic      [15:0] obj_wdata,
  input  wire logic [15:0] obj_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Idle drive
  initial
  begin
    obj_wr    = 1'b0;
    obj_index = dpc_pkg::IDX_CTRL;
    obj_wdata = 16'h0000;
  end
  // ==========================================================
  // Access tasks
  // master writes one object
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(negedge sys_clk);
    obj_wr    = 1'b1;
    obj_index = idx;
    obj_wdata = d;
    @(negedge sys_clk);
    obj_wr    = 1'b0;
    // Stale data inverted so nothing leans on a held value
    obj_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [15:0] d);
    @(negedge sys_clk);
    obj_index = idx;
    repeat (2) @(negedge sys_clk);
    d = obj_rdata;
  endtask
  // low then high on bit 7
  task automatic fault_reset(input logic [15:0] cw);
    wr(dpc_pkg::IDX_CTRL, cw & 16'hff7f);
    wr(dpc_pkg::IDX_CTRL, cw | 16'h0080);
  endtask
endmodule
`default_nettype wire

// ===== drive_profile_control_status_tb_top.sv
/*
  Self-checking bench for the drive profile object bank.
  Assumes pin filters settle within eight cycles.
*/
`default_nettype none
module drive_profile_control_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [15:0] idx; logic [15:0] wd; logic [15:0] ex;} dpc_row_t;
  logic        sys_clk, sys_rst, obj_wr, alarm_raise, info_cond, limit_cond, init_done, motor_stopped;
  logic        halt_req, current_off;
  logic [15:0] obj_index, obj_wdata, obj_rdata, rdw;
  logic [7:0]  alarm_code;
  logic [2:0]  mode_bits, stop_mode;
  int          miscompares, tests_run;
  dpc_row_t    rows [12];
  // ==========================================================
  // Design and master
  dpc_bank dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .alarm_raise(alarm_raise),
    .alarm_code(alarm_code), .info_cond(info_cond), .limit_cond(limit_cond),
    .init_done(init_done), .motor_stopped(motor_stopped), .mode_bits(mode_bits),
    .halt_req(halt_req), .stop_mode(stop_mode), .current_off(current_off)
  );
  dpc_master_model mst (
    .sys_clk(sys_clk), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Checking
  task automatic chk_word(input logic [15:0] got, input logic [15:0] ex);
    tests_run++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[ERR] %0t word got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic chk_out(input logic [2:0] got, input logic [2:0] ex);
    tests_run++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[ERR] %0t output got %b expected %b", $time, got, ex);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Run is under two hundred cycles; this bound is far beyond it
  initial
  begin
    #(3000 * 100);
    miscompares++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {miscompares, tests_run} = '0;
    {alarm_raise, info_cond, limit_cond, init_done, motor_stopped} = '0;
    alarm_code = 8'h00;
    sys_rst    = 1'b1;
    rows = '{'{0, dpc_pkg::IDX_CTRL, 16'h0, 16'h0000}, '{0, dpc_pkg::IDX_QSOPT, 16'h0, 16'h0002},
             '{0, dpc_pkg::IDX_ERROR, 16'h0, 16'h0000}, '{1, dpc_pkg::IDX_QSOPT, 16'h0000, 16'h0000},
             '{1, dpc_pkg::IDX_QSOPT, 16'h0001, 16'h0001}, '{1, dpc_pkg::IDX_QSOPT, 16'h0003, 16'h0003},
             '{1, dpc_pkg::IDX_QSOPT, 16'h0007, 16'h0007}, '{1, dpc_pkg::IDX_QSOPT, 16'h0004, 16'h0007},
             '{1, dpc_pkg::IDX_QSOPT, 16'h0008, 16'h0007}, '{1, dpc_pkg::IDX_ERROR, 16'hffff, 16'h0000},
             '{1, dpc_pkg::IDX_CTRL, 16'h0070, 16'h0070}, '{1, 16'h1234, 16'h5555, 16'h0000}};
    wait_cyc(8);
    sys_rst = 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        mst.wr(rows[i].idx, rows[i].wd);
      mst.rd(rows[i].idx, rdw);
      chk_word(rdw, rows[i].ex);
    end
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h0200, 16'h0000);
    init_done = 1'b1;
    wait_cyc(4);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h024f, 16'h0240);
    // Shutdown, switch on, enable operation
    mst.wr(dpc_pkg::IDX_CTRL, 16'h0006);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h006f, 16'h0021);
    mst.wr(dpc_pkg::IDX_CTRL, 16'h0007);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h006f, 16'h0023);
    mst.wr(dpc_pkg::IDX_CTRL, 16'h007f);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h006f, 16'h0027);
    chk_out(mode_bits, 3'b111);
    mst.wr(dpc_pkg::IDX_CTRL, 16'h012f);
    wait_cyc(3);
    chk_out({mode_bits[0], halt_req, 1'b0}, 3'b010);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h006f, 16'h0027);
    // Quick stop with motor still turning, option change deferred
    mst.wr(dpc_pkg::IDX_QSOPT, 16'h0005);
    mst.wr(dpc_pkg::IDX_CTRL, 16'h000b);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h006f, 16'h0007);
    chk_out(stop_mode, 3'd5);
    mst.wr(dpc_pkg::IDX_QSOPT, 16'h0006);
    wait_cyc(3);
    chk_out(stop_mode, 3'd5);
    motor_stopped = 1'b1;
    wait_cyc(3);
    chk_out(stop_mode, 3'd6);
    // Option zero: current off stands one cycle before the stopped motor leaves
    mst.wr(dpc_pkg::IDX_QSOPT, 16'h0000);
    chk_out({current_off, stop_mode[1:0]}, 3'b100);
    wait_cyc(3);
    chk_out({current_off, stop_mode[1:0]}, 3'h0);
    // Information and limit conditions
    {info_cond, limit_cond} = 2'b11;
    wait_cyc(8);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h0880, 16'h0880);
    {info_cond, limit_cond} = 2'b00;
    wait_cyc(8);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h0880, 16'h0000);
    // Alarm; bit 7 held high must not clear it
    mst.wr(dpc_pkg::IDX_CTRL, 16'h0080);
    alarm_code  = 8'h3c;
    alarm_raise = 1'b1;
    wait_cyc(8);
    alarm_raise = 1'b0;
    wait_cyc(8);
    mst.rd(dpc_pkg::IDX_ERROR, rdw);
    chk_word(rdw, 16'hff3c);
    mst.rd(dpc_pkg::IDX_STATUS, rdw);
    chk_word(rdw & 16'h004f, 16'h0008);
    mst.wr(dpc_pkg::IDX_CTRL, 16'h0080);
    mst.rd(dpc_pkg::IDX_ERROR, rdw);
    chk_word(rdw, 16'hff3c);
    mst.fault_reset(16'h0000);
    mst.rd(dpc_pkg::IDX_ERROR, rdw);
    chk_word(rdw, 16'h0000);
    // Reset in mid-run brings objects back to reset values
    mst.wr(dpc_pkg::IDX_QSOPT, 16'h0003);
    sys_rst = 1'b1;
    wait_cyc(2);
    chk_word(obj_rdata, 16'h0000);
    sys_rst = 1'b0;
    mst.rd(dpc_pkg::IDX_QSOPT, rdw);
    chk_word(rdw, 16'h0002);
    mst.rd(dpc_pkg::IDX_CTRL, rdw);
    chk_word(rdw, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
